//--- spi_evt_regs.vh
// Register map, field positions and reset values of the serial event and baud block.
`ifndef SPI_EVT_REGS_VH
`define SPI_EVT_REGS_VH
// ==========================================================================
// Register byte offsets.
`define OFS_CTRL        6'h00
`define OFS_STATUS      6'h04
`define OFS_ELEMENTS    6'h08
`define OFS_EVT_ENABLE  6'h0C
`define OFS_WMARK       6'h10
`define OFS_BAUD        6'h14
`define OFS_BUFFER      6'h18
`define OFS_IRQ_STAT    6'h1C
`define OFS_IRQ_MASK    6'h20
`define ADDR_W          6
// ==========================================================================
// Control register fields.
`define CTRL_ENABLE     0
`define CTRL_ENHANCED   1
// Status / event enable bit positions.
`define ST_RX_FULL      0
`define ST_TX_FULL      1
`define ST_TX_EMPTY     3
`define ST_RX_EMPTY     5
`define ST_OVERFLOW     6
`define ST_SHIFT_EMPTY  7
`define ST_UNDERRUN     8
`define ST_ACTIVITY     11
// Watermark register fields.
`define WM_TX_LVL_LSB   0
`define WM_TX_EN        7
`define WM_RX_LVL_LSB   8
`define WM_RX_EN        15
// Interrupt status bit positions.
`define IRQ_EVENT       0
`define IRQ_RX_WMARK    1
`define IRQ_TX_WMARK    2
// ==========================================================================
// Sizes and reset values.
`define FIFO_DEPTH      6'h10
`define WORD_W          8
`define BAUD_W          13
`define EVT_MASK        16'h09EB
`define RST_ZERO        16'h0000
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

//--- spi_baud_gen.v
// Serial clock divider: toggles the serial clock every divider plus one cycles.
`timescale 1ns/10ps
`default_nettype none
`include "spi_evt_regs.vh"
module spi_baud_gen (
	input  wire                 clk_i,   // Peripheral clock.
	input  wire                 nrst_i,  // Asynchronous reset, active low.
	input  wire                 ce_i,    // Clock enable.
	input  wire                 run_i,   // Divider runs while high.
	input  wire [`BAUD_W-1:0]   div_i,   // Divider register value.
	output reg                  sck_o,   // Divided serial clock.
	output reg                  tick_o   // Pulse at each falling serial edge.
);
	reg [`BAUD_W-1:0] cnt_r;

	// ======================================================================
	// Half period of div+1 cycles gives clk/(2*(div+1)).
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_r  <= {`BAUD_W{1'b0}};
			sck_o  <= 1'b0;
			tick_o <= 1'b0;
		end else if (ce_i) begin
			tick_o <= 1'b0;
			if (!run_i) begin
				cnt_r <= {`BAUD_W{1'b0}};
				sck_o <= 1'b0;
			end else if (cnt_r >= div_i) begin
				cnt_r  <= {`BAUD_W{1'b0}};
				sck_o  <= ~sck_o;
				tick_o <= sck_o;
			end else begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end
endmodule // spi_baud_gen
`default_nettype wire

//--- spi_event_top.v
// Serial interface event, watermark, buffer window and baud logic with AXI4-Lite registers.
//
// Summary of operation
// - Activity flag raises event when enabled.
// - Underrun raises event when enabled.
// - Shift empty raises event when enabled.
// - Overflow raises event when enabled.
// - Receive empty raises event when enabled.
// - Level bits exist per FIFO depth.
// - Serial clock is clk over 2(div+1).
// - One buffer address: write transmit, read receive.
// - Six-bit element counts feed watermark compare.
// - Word arriving into full receive sets overflow.
`timescale 1ns/10ps
`default_nettype none
`include "spi_evt_regs.vh"
module spi_event_top (
	input  wire                 clk_i,          // Peripheral clock, 250 MHz.
	input  wire                 nrst_i,         // Asynchronous reset, active low.
	input  wire                 ce_i,           // Clock enable, freezes state when low.
	input  wire [`ADDR_W-1:0]   s_axi_awaddr,   // Write address.
	input  wire                 s_axi_awvalid,  // Write address valid.
	output reg                  s_axi_awready,  // Write address ready.
	input  wire [31:0]          s_axi_wdata,    // Write data.
	input  wire [3:0]           s_axi_wstrb,    // Write byte strobes.
	input  wire                 s_axi_wvalid,   // Write data valid.
	output reg                  s_axi_wready,   // Write data ready.
	output reg  [1:0]           s_axi_bresp,    // Write response.
	output reg                  s_axi_bvalid,   // Write response valid.
	input  wire                 s_axi_bready,   // Write response ready.
	input  wire [`ADDR_W-1:0]   s_axi_araddr,   // Read address.
	input  wire                 s_axi_arvalid,  // Read address valid.
	output reg                  s_axi_arready,  // Read address ready.
	output reg  [31:0]          s_axi_rdata,    // Read data.
	output reg  [1:0]           s_axi_rresp,    // Read response.
	output reg                  s_axi_rvalid,   // Read data valid.
	input  wire                 s_axi_rready,   // Read data ready.
	input  wire                 sdi_i,          // Serial data in.
	output reg                  sdo_o,          // Serial data out.
	output reg                  sck_o,          // Serial clock out.
	output reg                  irq_o           // Interrupt, level, active high.
);
	localparam CW = 6;                           // Element count width.
	localparam [CW-1:0] DEPTH = `FIFO_DEPTH;
	// Level bit 2 needs depth 8, bit 3 needs 16 and bit 4 needs 32; bit 5 is
	// never kept, so absent bits always read back as zero.
	localparam [CW-1:0] LVL_MASK = (DEPTH >= 6'd32) ? 6'h1F :
	                                (DEPTH >= 6'd16) ? 6'h0F :
	                                (DEPTH >= 6'd8)  ? 6'h07 : 6'h03;
	// Event enable bits that exist; the rest read as zero.
	localparam [15:0] EN_MASK = `EVT_MASK;

	// ======================================================================
	// Registers.
	reg  [1:0]           ctrl_r;
	reg  [15:0]          evt_en_r;
	reg  [15:0]          wmark_r;
	reg  [`BAUD_W-1:0]   baud_r;
	reg  [2:0]           irq_stat_r;
	reg  [2:0]           irq_mask_r;
	reg  [`WORD_W-1:0]   tx_mem [0:15];
	reg  [`WORD_W-1:0]   rx_mem [0:15];
	reg  [3:0]           tx_rd_r, tx_wr_r, rx_rd_r, rx_wr_r;
	reg  [CW-1:0]        tx_cnt_r, rx_cnt_r;
	reg                  overflow_r, underrun_r;
	reg  [`WORD_W-1:0]   shreg_r, rxsh_r;
	reg  [3:0]           bit_r;
	reg                  active_r;
	reg  [`ADDR_W-1:0]   aw_r;
	reg  [31:0]          wd_r;
	reg  [3:0]           ws_r;
	reg                  aw_ok_r, w_ok_r;
	wire                 sck_w, tick_w;
	wire                 baud_run;

	// ======================================================================
	// Baud divider runs only while a word is being shifted, so the serial
	// clock stands still low between words.
	spi_baud_gen u_baud (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.ce_i   (ce_i),
		.run_i  (baud_run),
		.div_i  (baud_r),
		.sck_o  (sck_w),
		.tick_o (tick_w)
	);

	// ======================================================================
	// Status flags; standard mode sees the buffers as one entry deep.
	wire enh       = ctrl_r[`CTRL_ENHANCED];
	wire [CW-1:0] cap = enh ? DEPTH : 6'd1;
	wire tx_empty  = (tx_cnt_r == 6'd0);
	wire tx_full   = (tx_cnt_r == cap);
	wire rx_empty  = (rx_cnt_r == 6'd0);
	wire rx_full   = (rx_cnt_r == cap);
	wire shift_mt  = tx_empty && !active_r;
	wire [15:0] status;
	assign status = {4'h0, active_r, 2'b00, underrun_r, shift_mt, overflow_r,
	                 rx_empty, 1'b0, tx_empty, 1'b0, tx_full, rx_full};

	// Each enabled flag raises the shared event line.
	wire event_any = |(status & evt_en_r & `EVT_MASK);

	// Watermark compare; level bits above LVL_MASK are dropped, so a level written above depth compares by its low bits.
	wire [CW-1:0] rx_lvl = wmark_r[`WM_RX_LVL_LSB +: CW] & LVL_MASK;
	wire [CW-1:0] tx_lvl = wmark_r[`WM_TX_LVL_LSB +: CW] & LVL_MASK;
	wire rx_wm = wmark_r[`WM_RX_EN] && (rx_lvl <= DEPTH) && (rx_lvl <= rx_cnt_r);
	wire tx_wm = wmark_r[`WM_TX_EN] && (tx_lvl <= DEPTH) && (tx_lvl == tx_cnt_r);
	wire [2:0] irq_src = {tx_wm, rx_wm, event_any};

	// ======================================================================
	// Bus decode for the write that completes this cycle.
	wire wr_go   = aw_ok_r && w_ok_r && !s_axi_bvalid;
	wire rd_go   = s_axi_arvalid && s_axi_arready;
	wire wr_buf  = wr_go && (aw_r == `OFS_BUFFER) && ws_r[0];
	wire rd_buf  = rd_go && (s_axi_araddr == `OFS_BUFFER);
	// Software writes push transmit data, reads pop receive data.
	wire tx_push = wr_buf && !tx_full && ctrl_r[`CTRL_ENABLE];
	wire rx_pop  = rd_buf && !rx_empty;
	wire tx_pop  = !active_r && !tx_empty && ctrl_r[`CTRL_ENABLE];
	wire word_done = active_r && tick_w && (bit_r == 4'd`WORD_W - 4'd1);
	// The divider stops on the edge that ends a word; left running, a zero
	// divider would show one stray serial clock pulse after the last bit.
	assign baud_run = active_r && !word_done;
	// A received word only exists because a transmit was started.
	wire rx_push = word_done && !rx_full;

	// ======================================================================
	// Write channel: address and data taken in either order.
	// A new request is held off while a response waits: one write at a time.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			aw_ok_r <= 1'b0;
			w_ok_r  <= 1'b0;
			aw_r    <= {`ADDR_W{1'b0}};
			wd_r    <= 32'h00000000;
			ws_r    <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `RESP_OKAY;
		end else if (ce_i) begin
			s_axi_awready <= !aw_ok_r && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
			s_axi_wready  <= !w_ok_r && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_r <= 1'b1;
				aw_r    <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_r <= 1'b1;
				wd_r   <= s_axi_wdata;
				ws_r   <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_ok_r <= 1'b0;
				w_ok_r  <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_r[1:0] != 2'b00 || aw_r > `OFS_IRQ_MASK) ?
				                `RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Software registers; byte strobes select the lanes written.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ctrl_r     <= 2'b00;
			evt_en_r   <= `RST_ZERO;
			wmark_r    <= `RST_ZERO;
			baud_r     <= {`BAUD_W{1'b0}};
			irq_mask_r <= 3'b000;
		end else if (ce_i && wr_go) begin
			if (aw_r == `OFS_CTRL && ws_r[0])
				ctrl_r <= wd_r[1:0];
			if (aw_r == `OFS_EVT_ENABLE) begin
				if (ws_r[0])
					evt_en_r[7:0] <= wd_r[7:0] & EN_MASK[7:0];
				if (ws_r[1])
					evt_en_r[15:8] <= wd_r[15:8] & EN_MASK[15:8];
			end else if (aw_r == `OFS_WMARK) begin
				if (ws_r[0])
					wmark_r[7:0] <= wd_r[7:0] & {1'b1, 1'b0, LVL_MASK};
				if (ws_r[1])
					wmark_r[15:8] <= wd_r[15:8] & {1'b1, 1'b0, LVL_MASK};
			end else if (aw_r == `OFS_BAUD) begin
				if (ws_r[0])
					baud_r[7:0] <= wd_r[7:0];
				if (ws_r[1])
					baud_r[`BAUD_W-1:8] <= wd_r[`BAUD_W-1:8];
			end else if (aw_r == `OFS_IRQ_MASK && ws_r[0]) begin
				irq_mask_r <= wd_r[2:0];
			end
		end
	end

	// ======================================================================
	// Sticky interrupt status: a new event wins over a write-one clear.
	// The interrupt line lags the status by one cycle, as it comes from a flop.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			irq_stat_r <= 3'b000;
			irq_o      <= 1'b0;
		end else if (ce_i) begin
			irq_stat_r <= (irq_stat_r &
			              ~((wr_go && aw_r == `OFS_IRQ_STAT && ws_r[0]) ? wd_r[2:0] : 3'b000))
			              | irq_src;
			irq_o <= |(irq_stat_r & irq_mask_r);
		end
	end

	// ======================================================================
	// Read channel: one-cycle address accept, data the next cycle.
	// The data register keeps its value after the handshake, so the bus does
	// not toggle between reads.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `RESP_OKAY;
		end else if (ce_i) begin
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `RESP_OKAY;
				if (s_axi_araddr == `OFS_CTRL)
					s_axi_rdata <= {30'h0, ctrl_r};
				else if (s_axi_araddr == `OFS_STATUS)
					s_axi_rdata <= {16'h0, status};
				else if (s_axi_araddr == `OFS_ELEMENTS)
					s_axi_rdata <= {18'h0, rx_cnt_r, 2'b00, tx_cnt_r};
				else if (s_axi_araddr == `OFS_EVT_ENABLE)
					s_axi_rdata <= {16'h0, evt_en_r};
				else if (s_axi_araddr == `OFS_WMARK)
					s_axi_rdata <= {16'h0, wmark_r};
				else if (s_axi_araddr == `OFS_BAUD)
					s_axi_rdata <= {19'h0, baud_r};
				else if (s_axi_araddr == `OFS_BUFFER)
					s_axi_rdata <= {24'h0, rx_mem[rx_rd_r]};
				else if (s_axi_araddr == `OFS_IRQ_STAT)
					s_axi_rdata <= {29'h0, irq_stat_r};
				else if (s_axi_araddr == `OFS_IRQ_MASK)
					s_axi_rdata <= {29'h0, irq_mask_r};
				else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ======================================================================
	// Buffers and element counts. Reads of an empty receive buffer return
	// the stale entry without moving the pointer.
	always @(posedge clk_i) begin
		if (ce_i && tx_push)
			tx_mem[tx_wr_r] <= wd_r[`WORD_W-1:0];
		if (ce_i && rx_push)
			rx_mem[rx_wr_r] <= {rxsh_r[`WORD_W-2:0], sdi_i};
	end

	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			tx_rd_r <= 4'h0;
			tx_wr_r <= 4'h0;
			rx_rd_r <= 4'h0;
			rx_wr_r <= 4'h0;
			tx_cnt_r <= 6'd0;
			rx_cnt_r <= 6'd0;
			overflow_r <= 1'b0;
			underrun_r <= 1'b0;
		end else if (ce_i) begin
			if (tx_push)
				tx_wr_r <= tx_wr_r + 4'h1;
			if (tx_pop)
				tx_rd_r <= tx_rd_r + 4'h1;
			if (rx_push)
				rx_wr_r <= rx_wr_r + 4'h1;
			if (rx_pop)
				rx_rd_r <= rx_rd_r + 4'h1;
			tx_cnt_r <= tx_cnt_r + {5'd0, tx_push} - {5'd0, tx_pop};
			rx_cnt_r <= rx_cnt_r + {5'd0, rx_push} - {5'd0, rx_pop};
			// Overflow is sticky; set wins over a write-one clear.
			if (word_done && rx_full)
				overflow_r <= 1'b1;
			else if (wr_go && aw_r == `OFS_STATUS && ws_r[0] && wd_r[`ST_OVERFLOW])
				overflow_r <= 1'b0;
			// Underrun: word finished with nothing queued; cleared by disable.
			if (!ctrl_r[`CTRL_ENABLE])
				underrun_r <= 1'b0;
			else if (word_done && tx_empty && !tx_push)
				underrun_r <= 1'b1;
			else if (tx_push)
				underrun_r <= 1'b0;
		end
	end

	// ======================================================================
	// Shifter: MSB first; input sampled and output moved at the falling serial edge.
	// The first bit is driven when the word is loaded, so the far side sees it
	// before the first rising serial edge.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			shreg_r  <= {`WORD_W{1'b0}};
			rxsh_r   <= {`WORD_W{1'b0}};
			bit_r    <= 4'h0;
			active_r <= 1'b0;
			sdo_o    <= 1'b0;
			sck_o    <= 1'b0;
		end else if (ce_i) begin
			sck_o <= sck_w;
			if (tx_pop) begin
				shreg_r  <= tx_mem[tx_rd_r];
				sdo_o    <= tx_mem[tx_rd_r][`WORD_W-1];
				bit_r    <= 4'h0;
				active_r <= 1'b1;
			end else if (active_r && tick_w) begin
				rxsh_r  <= {rxsh_r[`WORD_W-2:0], sdi_i};
				shreg_r <= {shreg_r[`WORD_W-2:0], 1'b0};
				sdo_o   <= shreg_r[`WORD_W-2];
				bit_r   <= bit_r + 4'h1;
				if (word_done)
					active_r <= 1'b0;
			end
		end
	end
endmodule // spi_event_top
`default_nettype wire

//--- spi_event_chk.sv
// Checker of register bus and interrupt behaviour at the serial event block's ports.
`timescale 1ns/10ps
`default_nettype none
`include "spi_evt_regs.vh"
module spi_event_chk (
	input wire logic               clk_i,         // Clock.
	input wire logic               nrst_i,        // Reset, active low.
	input wire logic [`ADDR_W-1:0] s_axi_awaddr,  // Write address.
	input wire logic               s_axi_awready, // Write address taken.
	input wire logic [31:0]        s_axi_wdata,   // Write data.
	input wire logic               s_axi_wvalid,  // Write data offered.
	input wire logic               s_axi_wready,  // Write data taken.
	input wire logic               s_axi_bvalid,  // Write answer.
	input wire logic               s_axi_bready,  // Write answer taken.
	input wire logic [`ADDR_W-1:0] s_axi_araddr,  // Read address.
	input wire logic               s_axi_arready, // Read address taken.
	input wire logic [31:0]        s_axi_rdata,   // Read data.
	input wire logic [1:0]         s_axi_rresp,   // Read answer code.
	input wire logic               s_axi_rvalid,  // Read answer.
	input wire logic               irq_o          // Interrupt.
);
	// ====================================================================
	// Helper state
	logic mask_zero_r;
	// Follows whether software last cleared the whole interrupt mask.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			mask_zero_r <= 1'b1;
		end else if (s_axi_wvalid && s_axi_wready && s_axi_awaddr == `OFS_IRQ_MASK) begin
			mask_zero_r <= (s_axi_wdata[2:0] == 3'h0);
		end
	end
	// ====================================================================
	// Properties
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence wr_taken;
		s_axi_awready && s_axi_wready;
	endsequence
	sequence rd_taken;
		s_axi_arready;
	endsequence
	aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
		else $error("write address ready held too long");
	ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready)
		else $error("read address ready held too long");
	write_resp_a: assert property (wr_taken |=> ##1 s_axi_bvalid)
		else $error("write answer late");
	read_resp_a: assert property (rd_taken |=> s_axi_rvalid)
		else $error("read answer late");
	write_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer not withdrawn");
	bad_read_a: assert property (rd_taken ##0 (s_axi_araddr > 6'h20) |=>
		s_axi_rresp == `RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	wmark_bits_a: assert property (rd_taken ##0 (s_axi_araddr == `OFS_WMARK) |=>
		(s_axi_rdata & 32'hFFFF7070) == 32'h0)
		else $error("absent level bits read as one");
	mask_quiet_a: assert property (mask_zero_r && $past(mask_zero_r, 3) |-> !irq_o)
		else $error("interrupt with cleared mask");
endmodule // spi_event_chk
`default_nettype wire

//--- spi_peer_model.sv
// Serial peer model: returns one byte MSB first per word and keeps the byte it is sent.
`timescale 1ns/10ps
`default_nettype none
module spi_peer_model (
	input  wire logic       clk_i,   // Clock.
	input  wire logic       nrst_i,  // Reset, active low.
	input  wire logic       sck_i,   // Serial clock.
	input  wire logic       sdo_i,   // Data from the block.
	input  wire logic [7:0] reply_i, // Byte to return.
	output logic            sdi_o,   // Data to the block.
	output logic [7:0]      got_o,   // Byte taken, valid at done.
	output logic            done_o   // Pulse when a word ends.
);
	logic       sck_r;
	logic       bit_r;
	logic [2:0] cnt_r;
	// ====================================================================
	// Capture takes the bit held while the clock was high, so either launch edge works.
	always @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			{sck_r, bit_r, cnt_r, got_o, done_o} <= '0;
		end else begin
			sck_r <= sck_i;
			done_o <= sck_r && !sck_i && cnt_r == 3'h7;
			if (sck_i) bit_r <= sdo_i;
			if (sck_r && !sck_i) begin
				got_o <= {got_o[6:0], bit_r};
				cnt_r <= cnt_r + 3'h1;
			end
		end
	end
	// Bit moves only after a fall, so it is steady when the block samples it.
	assign sdi_o = reply_i[3'h7 - cnt_r];
endmodule // spi_peer_model
`default_nettype wire

//--- spi_interrupt_event_and_baud_tb.sv
// Self-checking bench of the serial event and baud block with a serial peer.
`timescale 1ns/10ps
`default_nettype none
`include "spi_evt_regs.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module spi_interrupt_event_and_baud_tb;
	logic        clk_i, nrst_i, ce_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, sdi_i, sdo_o, sck_o, irq_o, done;
	logic [5:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [7:0]  reply_r, rx_r, tx_r, got;
	logic [12:0] div_r;
	logic [63:0] note_r;
	logic [63:0] notes[$];
	int          fails, checks_done, n;
	// ====================================================================
	// Design and serial peer
	spi_event_top u_dut (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sdi_i(sdi_i), .sdo_o(sdo_o),
		.sck_o(sck_o), .irq_o(irq_o));
	spi_peer_model u_peer (.clk_i(clk_i), .nrst_i(nrst_i), .sck_i(sck_o), .sdo_i(sdo_o),
		.reply_i(reply_r), .sdi_o(sdi_i), .got_o(got), .done_o(done));
	// Free-running 250 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// ====================================================================
	// Tasks
	task automatic test_done;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// A wait that used its whole bound ends the run as a mismatch.
	task automatic bail(input int k);
		if (k >= 400) begin
			fails++;
			test_done;
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
		int k;
		@(posedge clk_i);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		for (k = 0; k < 400; k++) begin
			@(posedge clk_i);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		bail(k);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, e)
	endtask
	// Notes the expected value under a mask; the monitor compares it.
	task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
		int k;
		@(posedge clk_i);
		notes.push_back({m, e});
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		for (k = 0; k < 400; k++) begin
			@(posedge clk_i);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		bail(k);
		s_axi_rready <= 1'b0;
	endtask
	task automatic hold(input logic v, output int k);
		for (k = 0; sck_o === v; k++) begin
			@(negedge clk_i);
			bail(k);
		end
	endtask
	// One word; the first high phase is timed, since the first low phase may start mid-write.
	task automatic xfer;
		int k;
		tx_r = 8'($urandom);
		reply_r <= 8'($urandom);
		wr(`OFS_BUFFER, {24'h0, tx_r}, `RESP_OKAY);
		@(negedge clk_i);
		hold(1'b1, k);
		hold(1'b0, k);
		hold(1'b1, k);
		`CHK(k, div_r + 1)
		for (k = 0; !done; k++) begin
			@(negedge clk_i);
			bail(k);
		end
		`CHK(got, tx_r)
		rx_r = reply_r;
	endtask
	// Source off: no event; source on: sticky event and interrupt; clear drops it.
	task automatic evt(input int b);
		wr(`OFS_EVT_ENABLE, 32'h0, `RESP_OKAY);
		wr(`OFS_IRQ_STAT, 32'h7, `RESP_OKAY);
		rd(`OFS_IRQ_STAT, 32'h0, 32'h1);
		wr(`OFS_EVT_ENABLE, 32'h1 << b, `RESP_OKAY);
		rd(`OFS_IRQ_STAT, 32'h1, 32'h1);
		repeat (2) @(negedge clk_i);
		`CHK(irq_o, 1'b1)
		wr(`OFS_EVT_ENABLE, 32'h0, `RESP_OKAY);
		wr(`OFS_IRQ_STAT, 32'h7, `RESP_OKAY);
		repeat (2) @(negedge clk_i);
		`CHK(irq_o, 1'b0)
	endtask
	// ====================================================================
	// Read monitor: oldest note against the returned data.
	always @(posedge clk_i) begin
		if (s_axi_rvalid && s_axi_rready) begin
			note_r = notes.pop_front();
			`CHK(s_axi_rdata & note_r[63:32], note_r[31:0])
		end
	end
	// Main sequence.
	initial begin
		{nrst_i, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, reply_r, div_r} = '0;
		{ce_i, s_axi_wstrb} = 5'h1F;
		void'($urandom(32'h5DA0));
		repeat (20) @(posedge clk_i);
		nrst_i <= 1'b1;
		rd(`OFS_EVT_ENABLE, 32'h0, 32'hFFFFFFFF);
		rd(`OFS_WMARK, 32'h0, 32'hFFFFFFFF);
		rd(6'h24, 32'h0, 32'hFFFFFFFF);
		wr(6'h02, 32'h1, `RESP_SLVERR);
		wr(`OFS_WMARK, 32'hFFFF, `RESP_OKAY);
		rd(`OFS_WMARK, 32'h8F8F, 32'hFFFFFFFF);
		wr(`OFS_WMARK, 32'h0, `RESP_OKAY);
		wr(`OFS_CTRL, 32'h1, `RESP_OKAY);
		wr(`OFS_IRQ_MASK, 32'h7, `RESP_OKAY);
		for (n = 3; n <= 7; n += 2) evt(n);
		div_r = 13'($urandom_range(3, 0));
		wr(`OFS_BAUD, {19'h0, div_r}, `RESP_OKAY);
		wr(`OFS_EVT_ENABLE, 32'h800, `RESP_OKAY);
		wr(`OFS_IRQ_STAT, 32'h7, `RESP_OKAY);
		xfer;
		rd(`OFS_IRQ_STAT, 32'h1, 32'h1);
		evt(0);
		evt(8);
		rd(`OFS_BUFFER, {24'h0, rx_r}, 32'hFF);
		xfer;
		xfer;
		rd(`OFS_STATUS, 32'h40, 32'h40);
		evt(6);
		wr(`OFS_STATUS, 32'h40, `RESP_OKAY);
		rd(`OFS_STATUS, 32'h0, 32'h40);
		rd(`OFS_BUFFER, 32'h0, 32'h0);
		wr(`OFS_CTRL, 32'h3, `RESP_OKAY);
		wr(`OFS_WMARK, 32'h8100, `RESP_OKAY);
		wr(`OFS_IRQ_STAT, 32'h7, `RESP_OKAY);
		rd(`OFS_IRQ_STAT, 32'h0, 32'h2);
		xfer;
		rd(`OFS_ELEMENTS, 32'h100, 32'h3F3F);
		rd(`OFS_IRQ_STAT, 32'h2, 32'h2);
		for (n = 0; n < 2; n++) begin
			wr(`OFS_WMARK, 32'h80 + n, `RESP_OKAY);
			wr(`OFS_IRQ_STAT, 32'h7, `RESP_OKAY);
			rd(`OFS_IRQ_STAT, n ? 32'h0 : 32'h4, 32'h4);
		end
		rd(`OFS_BUFFER, {24'h0, rx_r}, 32'hFF);
		// Frozen state: the request stays untaken until the clock enable returns.
		ce_i <= 1'b0;
		fork
			wr(`OFS_IRQ_MASK, 32'h0, `RESP_OKAY);
			begin
				repeat (10) @(posedge clk_i);
				`CHK(s_axi_awready | s_axi_bvalid, 1'b0)
				ce_i <= 1'b1;
			end
		join
		repeat (5) @(negedge clk_i);
		`CHK(irq_o, 1'b0)
		test_done;
	end
endmodule // spi_interrupt_event_and_baud_tb
bind spi_event_top spi_event_chk u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
	.s_axi_awaddr(s_axi_awaddr), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.irq_o(irq_o));
`default_nettype wire
